// ==== inc/sccc_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the control channel block.
// Included by the design file only; holds definitions only.
`ifndef SCCC_REGS_SVH
`define SCCC_REGS_SVH
`define SCCC_OFF_GENERAL_CONFIG_TWO 8'h04
`define SCCC_OFF_MASTER_CFG 8'h05
`define SCCC_OFF_DES_ADDR 8'h06
`define SCCC_OFF_SLAVE_PHYS 8'h07
`define SCCC_OFF_SLAVE_ALIAS 8'h08
`define SCCC_OFF_PORT_SELECT 8'h1E
`define SCCC_RESET_VALUE 8'h00
`define SCCC_CFG2_MASK 8'h03
`define SCCC_MASTER_MASK 8'h1F
`define SCCC_ADDR7_MASK 8'hFE
`define SCCC_ADDR_FREEZE_MASK 8'hFF
`define SCCC_PORT_SEL_MASK 8'h01
`define SCCC_BIT_CRC_OV_VAL 0
`define SCCC_BIT_CRC_OV_EN 1
`define SCCC_BIT_WD_DISABLE 0
`define SCCC_BIT_WD_FAST 1
`define SCCC_BIT_LOCAL_WR_BLOCK 2
`define SCCC_SDA_DLY_LSB 3
`define SCCC_BIT_FREEZE 0
`define SCCC_CLK_PERIOD_NS 8
`define SCCC_SDA_DLY_BASE_NS 200
`define SCCC_SDA_DLY_STEP_NS 40
`define SCCC_WD_FAST_NS 50000
`define SCCC_WD_SLOW_NS 1000000000
`define SCCC_CLEAR_HALF_NS 5000
`define SCCC_CLEAR_PULSES 9
`endif

// ==== inc/sccc_pkg.sv ====
// Types shared by the control channel block and its bench.
// Assumes nothing beyond the register header.
package sccc_pkg;
  typedef enum logic [1:0] {SCCC_FWD_NONE, SCCC_FWD_DES, SCCC_FWD_SLAVE} sccc_target_t;
  typedef struct packed {
    logic valid;
    sccc_target_t target;
    logic [6:0] addr;
  } sccc_fwd_t;
  typedef enum {SCCC_WD_WATCH, SCCC_WD_FREE, SCCC_WD_LOW, SCCC_WD_HIGH} sccc_wd_state_t;
endpackage : sccc_pkg

// ==== hdl/sccc_core.sv ====
// Control channel configuration: register file with two port copies, address
// remapping, SDA output delay, enhanced CRC selection and the bus watchdog.
// Assumes register accesses arrive already decoded from the I2C slave on clock_in,
// and that the bus pins come straight from the pads.
`timescale 1ns/1ps
`include "sccc_regs.svh"

// Behaviour
// - Override enable set: CRC follows override value.
// - Port-specific registers follow second port select.
// - SDA delayed 200 ns plus 40 ns steps.
// - Block remote writes to local registers.
// - Remote slave forwarding ignores write block.
// - Watchdog 50 us fast, one second slow.
// - Disable bit stops watchdog supervision.
// - SDA high through timeout: bus free.
// - SDA low through timeout: nine SCL pulses.
// - Deserializer address zero disables its access.
// - Auto-load deserializer address after lock unless frozen.
// - Freeze keeps software-written deserializer address.
// - Alias hits remapped to physical slave address.
// - Alias decoded; zero alias disables slave.
// - Override off: CRC follows deserializer capabilities.
module sccc_core #(
  parameter int WD_FAST_CYCLES = `SCCC_WD_FAST_NS / `SCCC_CLK_PERIOD_NS,
  parameter int WD_SLOW_CYCLES = `SCCC_WD_SLOW_NS / `SCCC_CLK_PERIOD_NS
) (
  // Clock, reset and clock enable
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Decoded register access
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic reg_remote_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_wr_refused_out,
  // Incoming transaction address to decode
  input wire logic addr_valid_in,
  input wire logic [6:0] addr_in,
  output sccc_pkg::sccc_fwd_t fwd_out,
  // Control channel events
  input wire logic rx_lock_in,
  input wire logic id_load_in,
  input wire logic id_load_port_in,
  input wire logic [6:0] id_load_addr_in,
  input wire logic [1:0] des_crc_cap_in,
  output logic [1:0] crc_enable_out,
  // Bus pins
  input wire logic scl_pin_in,
  input wire logic sda_pin_in,
  input wire logic sda_drive_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic scl_out,
  output logic scl_oe_out,
  output logic bus_free_out
);

  localparam int SDA_BASE_CYC = `SCCC_SDA_DLY_BASE_NS / `SCCC_CLK_PERIOD_NS;
  localparam int SDA_STEP_CYC = `SCCC_SDA_DLY_STEP_NS / `SCCC_CLK_PERIOD_NS;
  localparam int HALF_CYC = `SCCC_CLEAR_HALF_NS / `SCCC_CLK_PERIOD_NS;

  function automatic logic [7:0] sdly_cycles(input logic [1:0] code);
    sdly_cycles = 8'(SDA_BASE_CYC + SDA_STEP_CYC * int'(code));
  endfunction : sdly_cycles

  function automatic logic addr_hit(input logic [7:0] field, input logic [6:0] addr);
    addr_hit = (field[7:1] != 7'h00) && (field[7:1] == addr);
  endfunction : addr_hit

  // Register storage; port-specific registers hold one copy per transmit port.
  logic [7:0] cfg2_reg [2];
  logic [7:0] des_reg [2];
  logic [7:0] slv_reg [2];
  logic [7:0] alias_reg [2];
  logic [7:0] master_reg;
  logic [7:0] psel_reg;

  wire logic port_w = psel_reg[0];
  wire logic local_wr = reg_wr_in && !(reg_remote_in && master_reg[`SCCC_BIT_LOCAL_WR_BLOCK]);
  wire logic wr_blocked = reg_wr_in && reg_remote_in && master_reg[`SCCC_BIT_LOCAL_WR_BLOCK];
  wire logic wr_cfg2 = local_wr && (reg_addr_in == `SCCC_OFF_GENERAL_CONFIG_TWO);
  wire logic wr_master = local_wr && (reg_addr_in == `SCCC_OFF_MASTER_CFG);
  wire logic wr_des = local_wr && (reg_addr_in == `SCCC_OFF_DES_ADDR);
  wire logic wr_slv = local_wr && (reg_addr_in == `SCCC_OFF_SLAVE_PHYS);
  wire logic wr_alias = local_wr && (reg_addr_in == `SCCC_OFF_SLAVE_ALIAS);
  wire logic wr_psel = local_wr && (reg_addr_in == `SCCC_OFF_PORT_SELECT);
  wire logic hw_load = id_load_in && rx_lock_in && !des_reg[id_load_port_in][`SCCC_BIT_FREEZE];

  logic [7:0] rdata_mux;
  always_comb begin
    case (reg_addr_in)
      `SCCC_OFF_GENERAL_CONFIG_TWO: rdata_mux = cfg2_reg[port_w];
      `SCCC_OFF_MASTER_CFG: rdata_mux = master_reg;
      `SCCC_OFF_DES_ADDR: rdata_mux = des_reg[port_w];
      `SCCC_OFF_SLAVE_PHYS: rdata_mux = slv_reg[port_w];
      `SCCC_OFF_SLAVE_ALIAS: rdata_mux = alias_reg[port_w];
      `SCCC_OFF_PORT_SELECT: rdata_mux = psel_reg;
      default: rdata_mux = `SCCC_RESET_VALUE;
    endcase
  end

  // Register writes; a control channel load wins over a software write in the same cycle.
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 2; i++) begin
        cfg2_reg[i] <= `SCCC_RESET_VALUE;
        des_reg[i] <= `SCCC_RESET_VALUE;
        slv_reg[i] <= `SCCC_RESET_VALUE;
        alias_reg[i] <= `SCCC_RESET_VALUE;
      end
      master_reg <= `SCCC_RESET_VALUE;
      psel_reg <= `SCCC_RESET_VALUE;
      reg_rdata_out <= `SCCC_RESET_VALUE;
      reg_wr_refused_out <= 1'b0;
    end else if (ce_in) begin
      if (wr_cfg2) cfg2_reg[port_w] <= reg_wdata_in & `SCCC_CFG2_MASK;
      if (wr_master) master_reg <= reg_wdata_in & `SCCC_MASTER_MASK;
      if (wr_des) des_reg[port_w] <= reg_wdata_in & `SCCC_ADDR_FREEZE_MASK;
      if (wr_slv) slv_reg[port_w] <= reg_wdata_in & `SCCC_ADDR7_MASK;
      if (wr_alias) alias_reg[port_w] <= reg_wdata_in & `SCCC_ADDR7_MASK;
      if (wr_psel) psel_reg <= reg_wdata_in & `SCCC_PORT_SEL_MASK;
      if (hw_load) begin
        des_reg[id_load_port_in] <= {id_load_addr_in, 1'b0};
      end
      if (reg_rd_in) reg_rdata_out <= rdata_mux;
      reg_wr_refused_out <= wr_blocked;
    end
  end

  // Address decode against the selected port's copies.
  wire logic hit_des = addr_hit(des_reg[port_w], addr_in);
  wire logic hit_alias = addr_hit(alias_reg[port_w], addr_in);
  sccc_pkg::sccc_fwd_t fwd_next;
  always_comb begin
    fwd_next.valid = addr_valid_in;
    fwd_next.target = sccc_pkg::SCCC_FWD_NONE;
    fwd_next.addr = addr_in;
    if (hit_des) begin
      fwd_next.target = sccc_pkg::SCCC_FWD_DES;
    end else if (hit_alias) begin
      fwd_next.target = sccc_pkg::SCCC_FWD_SLAVE;
      fwd_next.addr = slv_reg[port_w][7:1];
    end
  end

  // Enhanced CRC selection per port.
  logic [1:0] crc_next;
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      crc_next[p] = cfg2_reg[p][`SCCC_BIT_CRC_OV_EN] ? cfg2_reg[p][`SCCC_BIT_CRC_OV_VAL]
                                                     : des_crc_cap_in[p];
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      fwd_out <= '0;
      crc_enable_out <= 2'h0;
    end else if (ce_in) begin
      fwd_out <= fwd_next;
      crc_enable_out <= crc_next;
    end
  end

  // Pin synchronisers and edge detection.
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_last_reg;
  logic sda_last_reg;
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_last_reg <= 1'b1;
      sda_last_reg <= 1'b1;
    end else if (ce_in) begin
      scl_sync_reg <= {scl_sync_reg[0], scl_pin_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_pin_in};
      scl_last_reg <= scl_sync_reg[1];
      sda_last_reg <= sda_sync_reg[1];
    end
  end
  wire logic scl_s = scl_sync_reg[1];
  wire logic sda_s = sda_sync_reg[1];
  wire logic scl_fall = scl_last_reg && !scl_s;
  wire logic activity = (scl_last_reg != scl_s) || (sda_last_reg != sda_s);

  // SDA output change is held back after each SCL falling edge.
  logic [7:0] sdly_cnt_reg;
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      sdly_cnt_reg <= 8'h00;
      sda_oe_out <= 1'b0;
    end else if (ce_in) begin
      if (scl_fall) begin
        sdly_cnt_reg <= sdly_cycles(master_reg[`SCCC_SDA_DLY_LSB +: 2]);
      end else if (sdly_cnt_reg != 8'h00) begin
        sdly_cnt_reg <= sdly_cnt_reg - 8'h01;
        if (sdly_cnt_reg == 8'h01) sda_oe_out <= sda_drive_in;
      end
    end
  end
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) sda_out <= 1'b0;
    else if (ce_in) sda_out <= 1'b0;
  end

  // Bus watchdog.
  sccc_pkg::sccc_wd_state_t wd_state_reg;
  logic [26:0] wd_cnt_reg;
  logic [3:0] pulse_cnt_reg;
  wire logic wd_off = master_reg[`SCCC_BIT_WD_DISABLE];
  wire logic [26:0] wd_limit = master_reg[`SCCC_BIT_WD_FAST] ? 27'(WD_FAST_CYCLES)
                                                             : 27'(WD_SLOW_CYCLES);
  wire logic wd_expired = (wd_cnt_reg >= wd_limit - 27'h1);
  wire logic half_done = (wd_cnt_reg >= 27'(HALF_CYC - 1));

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      wd_state_reg <= sccc_pkg::SCCC_WD_WATCH;
      wd_cnt_reg <= 27'h0;
      pulse_cnt_reg <= 4'h0;
      scl_oe_out <= 1'b0;
      bus_free_out <= 1'b0;
    end else if (ce_in) begin
      case (wd_state_reg)
        sccc_pkg::SCCC_WD_WATCH: begin
          scl_oe_out <= 1'b0;
          if (wd_off || activity) begin
            wd_cnt_reg <= 27'h0;
          end else if (wd_expired) begin
            wd_cnt_reg <= 27'h0;
            if (sda_s) begin
              wd_state_reg <= sccc_pkg::SCCC_WD_FREE;
              bus_free_out <= 1'b1;
            end else begin
              wd_state_reg <= sccc_pkg::SCCC_WD_LOW;
              pulse_cnt_reg <= 4'h0;
              scl_oe_out <= 1'b1;
            end
          end else begin
            wd_cnt_reg <= wd_cnt_reg + 27'h1;
          end
        end
        sccc_pkg::SCCC_WD_FREE: begin
          if (activity || wd_off) begin
            bus_free_out <= 1'b0;
            wd_state_reg <= sccc_pkg::SCCC_WD_WATCH;
          end
        end
        sccc_pkg::SCCC_WD_LOW: begin
          if (half_done) begin
            wd_cnt_reg <= 27'h0;
            scl_oe_out <= 1'b0;
            pulse_cnt_reg <= pulse_cnt_reg + 4'h1;
            wd_state_reg <= sccc_pkg::SCCC_WD_HIGH;
          end else begin
            wd_cnt_reg <= wd_cnt_reg + 27'h1;
          end
        end
        sccc_pkg::SCCC_WD_HIGH: begin
          if (half_done) begin
            wd_cnt_reg <= 27'h0;
            if (pulse_cnt_reg == 4'(`SCCC_CLEAR_PULSES)) begin
              wd_state_reg <= sccc_pkg::SCCC_WD_WATCH;
            end else begin
              scl_oe_out <= 1'b1;
              wd_state_reg <= sccc_pkg::SCCC_WD_LOW;
            end
          end else begin
            wd_cnt_reg <= wd_cnt_reg + 27'h1;
          end
        end
        default: begin
          wd_state_reg <= sccc_pkg::SCCC_WD_WATCH;
          scl_oe_out <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) scl_out <= 1'b0;
    else if (ce_in) scl_out <= 1'b0;
  end

endmodule : sccc_core

// ==== tb/sccc_bus_model.sv ====
// Far side of the pins: open-drain SCL and SDA with pull-ups, clocked by the link only in frames.
// Assumes the bench supplies the link clock, the frame window and a stuck-low request.
`timescale 1ns/1ps
module sccc_bus_model (
  // Link side
  input wire logic link_clk_in,
  input wire logic frame_in,
  input wire logic sda_hang_in,
  // Device pins
  input wire logic scl_oe_in,
  input wire logic sda_oe_in,
  output logic scl_pin_out,
  output logic sda_pin_out
);
  // Released lines float to the pull-up level; SCL ignores the link clock between frames.
  assign scl_pin_out = !(scl_oe_in || (frame_in && !link_clk_in));
  assign sda_pin_out = !(sda_oe_in || sda_hang_in);
endmodule : sccc_bus_model

// ==== tb/sccc_core_asserts.sv ====
// Port checker for the control channel block.
// Assumes the clock enable stays high while it watches.
`timescale 1ns/1ps
module sccc_core_asserts #(
  parameter int WD_FAST_CYCLES = 6250,
  parameter int WD_SLOW_CYCLES = 125000000
) (
  // Clock, reset and inputs
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic reg_remote_in,
  input wire logic addr_valid_in,
  input wire logic [6:0] addr_in,
  // Outputs
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_wr_refused_out,
  input wire sccc_pkg::sccc_fwd_t fwd_out,
  input wire logic sda_out,
  input wire logic scl_out,
  input wire logic scl_oe_out,
  input wire logic bus_free_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  chk_pins_low: assert property (!sda_out && !scl_out)
    else $error("pin data not low");
  chk_fwd_follows: assert property (addr_valid_in |=> fwd_out.valid)
    else $error("decode result missing");
  chk_fwd_idle: assert property (!addr_valid_in |=> !fwd_out.valid)
    else $error("decode result without request");
  chk_fwd_passthru: assert property (fwd_out.valid && fwd_out.target != sccc_pkg::SCCC_FWD_SLAVE
    |-> fwd_out.addr == $past(addr_in)) else $error("unmapped address altered");
  chk_refuse_cause: assert property (reg_wr_refused_out |-> $past(reg_wr_in && reg_remote_in))
    else $error("refusal without remote write");
  chk_local_wr_ok: assert property (reg_wr_in && !reg_remote_in |=> !reg_wr_refused_out)
    else $error("local write refused");
  chk_rdata_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data moved without read");
  chk_clear_pulse: assert property ($rose(scl_oe_out) |-> (scl_oe_out && !bus_free_out)[*8])
    else $error("clear pulse too short");
  cover property (fwd_out.valid && fwd_out.target == sccc_pkg::SCCC_FWD_SLAVE);
  cover property (reg_wr_refused_out);
  cover property ($rose(bus_free_out));
endmodule : sccc_core_asserts
bind sccc_core sccc_core_asserts #(.WD_FAST_CYCLES(WD_FAST_CYCLES),
  .WD_SLOW_CYCLES(WD_SLOW_CYCLES)) sccc_core_asserts_inst (.clock_in(clock_in),
  .rst_n_in(rst_n_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_remote_in(reg_remote_in), .addr_valid_in(addr_valid_in), .addr_in(addr_in),
  .reg_rdata_out(reg_rdata_out), .reg_wr_refused_out(reg_wr_refused_out), .fwd_out(fwd_out),
  .sda_out(sda_out), .scl_out(scl_out), .scl_oe_out(scl_oe_out), .bus_free_out(bus_free_out));

// ==== tb/test_serial_control_channel_config.sv ====
// Self-checking bench for the control channel block and its bus partner.
// Assumes the checker binds itself; watchdog counts are shortened to 200 and 400 cycles.
`timescale 1ns/1ps
module test_serial_control_channel_config;
  logic clock_in = 0, rst_n_in = 0, link_clk = 0, frame = 0, hang = 0, wr = 0, rd = 0;
  logic remote = 0, av = 0, ld = 0, ld_port = 0, lock = 0, sda_drive = 0, ce = 1;
  logic [7:0] addr = 0, wdata = 0, rdata, d;
  logic [6:0] a_in = 0, ld_addr = 0;
  logic [1:0] cap = 0, crc;
  logic refused, sda_o, sda_oe, scl_o, scl_oe, free, scl_pin, sda_pin;
  sccc_pkg::sccc_fwd_t fwd;
  int num_errors = 0, num_checks = 0, seed = 36, n;
  logic [7:0] sh [2][4];
  logic [7:0] pa [4] = '{8'h04, 8'h06, 8'h07, 8'h08};
  logic [7:0] mk [4] = '{8'h03, 8'hFF, 8'hFE, 8'hFE};
  sccc_core #(.WD_FAST_CYCLES(200), .WD_SLOW_CYCLES(400)) sccc_core_inst (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .ce_in(ce), .reg_wr_in(wr), .reg_rd_in(rd), .reg_remote_in(remote),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .reg_wr_refused_out(refused), .addr_valid_in(av), .addr_in(a_in), .fwd_out(fwd),
    .rx_lock_in(lock), .id_load_in(ld), .id_load_port_in(ld_port), .id_load_addr_in(ld_addr),
    .des_crc_cap_in(cap), .crc_enable_out(crc), .scl_pin_in(scl_pin), .sda_pin_in(sda_pin),
    .sda_drive_in(sda_drive), .sda_out(sda_o), .sda_oe_out(sda_oe), .scl_out(scl_o),
    .scl_oe_out(scl_oe), .bus_free_out(free));
  sccc_bus_model sccc_bus_model_inst (.link_clk_in(link_clk), .frame_in(frame),
    .sda_hang_in(hang), .scl_oe_in(scl_oe), .sda_oe_in(sda_oe), .scl_pin_out(scl_pin),
    .sda_pin_out(sda_pin));
  always #4 clock_in = ~clock_in;
  initial begin
    #3.7;
    forever #80 link_clk = ~link_clk;
  end
  task automatic tick(input int c);
    repeat (c) @(posedge clock_in);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wreg(input logic r, input logic [7:0] a, input logic [7:0] v, input logic x);
    {wr, remote, addr, wdata} = {1'b1, r, a, v};
    tick(1);
    wr = 0;
    chk("refused", refused, x);
    tick(1);
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    {rd, addr} = {1'b1, a};
    tick(1);
    rd = 0;
    chk("rdata", rdata, e);
    tick(1);
  endtask : rreg
  task automatic dec(input logic [6:0] a, input logic [15:0] e);
    {av, a_in} = {1'b1, a};
    tick(1);
    av = 0;
    chk("fwd", fwd, e);
    tick(1);
  endtask : dec
  task automatic load(input logic [6:0] a);
    {ld, ld_addr} = {1'b1, a};
    tick(1);
    ld = 0;
    tick(1);
  endtask : load
  task automatic wait_lv(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      tick(1);
      n++;
    end
  endtask : wait_lv
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  initial begin
    #400000;
    num_errors++;
    final_report();
  end
  initial begin
    tick(4);
    rst_n_in = 1;
    foreach (pa[i]) rreg(pa[i], 8'h00);
    wreg(0, 8'h20, 8'hFF, 0);
    rreg(8'h20, 8'h00);
    wreg(0, 8'h05, 8'hFF, 0);
    rreg(8'h05, 8'h1F);
    // With the clock enable low a write must leave the register untouched.
    ce = 0;
    wreg(0, 8'h05, 8'h00, 0);
    ce = 1;
    rreg(8'h05, 8'h1F);
    for (int p = 0; p < 4; p++) begin
      wreg(0, 8'h1E, {7'h0, p[0]}, 0);
      if (p == 3) rreg(8'h1E, 8'h01);
      foreach (pa[i]) begin
        if (p < 2) sh[p][i] = $random(seed);
        if (p < 2) wreg(0, pa[i], sh[p][i], 0);
        else rreg(pa[i], sh[p[0]][i] & mk[i]);
      end
    end
    for (int k = 0; k < 8; k++) begin
      wreg(0, 8'h1E, {7'h0, k[2]}, 0);
      wreg(0, 8'h04, {6'h0, k[1:0]}, 0);
      cap = $random(seed);
      tick(2);
      chk("crc", crc[k[2]], k[1] ? k[0] : cap[k[2]]);
    end
    wreg(0, 8'h1E, 8'h00, 0);
    d = $random(seed);
    wreg(0, 8'h06, 8'h54, 0);
    wreg(0, 8'h07, d, 0);
    wreg(0, 8'h08, 8'hAA, 0);
    wreg(0, 8'h05, 8'h04, 0);
    wreg(1, 8'h07, ~d, 1);
    rreg(8'h07, d & 8'hFE);
    dec(7'h55, {1'b1, sccc_pkg::SCCC_FWD_SLAVE, d[7:1]});
    dec(7'h2A, {1'b1, sccc_pkg::SCCC_FWD_DES, 7'h2A});
    dec(7'h11, {1'b1, sccc_pkg::SCCC_FWD_NONE, 7'h11});
    wreg(0, 8'h05, 8'h00, 0);
    wreg(1, 8'h08, 8'h00, 0);
    wreg(0, 8'h06, 8'h00, 0);
    dec(7'h55, {1'b1, sccc_pkg::SCCC_FWD_NONE, 7'h55});
    dec(7'h2A, {1'b1, sccc_pkg::SCCC_FWD_NONE, 7'h2A});
    lock = 1;
    load(7'h33);
    rreg(8'h06, 8'h66);
    wreg(0, 8'h06, 8'h49, 0);
    load(7'h12);
    rreg(8'h06, 8'h49);
    wreg(0, 8'h06, 8'h00, 0);
    lock = 0;
    load(7'h12);
    rreg(8'h06, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wreg(0, 8'h05, {3'h0, k[1:0], 3'h0}, 0);
      // One SCL fall per step: the link period is shorter than the SDA delay.
      wait_lv(link_clk, 1, 20);
      {sda_drive, frame} = 2'b11;
      wait_lv(scl_pin, 0, 40);
      tick(2);
      frame = 0;
      wait_lv(sda_oe, 1, 60);
      chk("sda delay", n >= 25 + 5 * k && n <= 30 + 5 * k, 1);
      sda_drive = 0;
      wait_lv(link_clk, 1, 20);
      frame = 1;
      wait_lv(scl_pin, 0, 40);
      tick(2);
      frame = 0;
      wait_lv(sda_oe, 0, 60);
      chk("sda release", sda_oe, 0);
      tick(20);
    end
    for (int k = 0; k < 3; k++) begin
      wreg(0, 8'h05, k == 2 ? 8'h01 : {6'h0, k[0], 1'b0}, 0);
      frame = 1;
      tick(40);
      frame = 0;
      chk("free", free, 0);
      wait_lv(free, 1, 600);
      chk("wd", k == 2 ? n == 600 : n >= (k ? 192 : 392) && n <= (k ? 212 : 412), 1);
    end
    wreg(0, 8'h05, 8'h02, 0);
    hang = 1;
    wait_lv(scl_oe, 1, 600);
    n = 0;
    repeat (11400) begin
      n += scl_oe;
      tick(1);
    end
    chk("clear", n, 5625);
    hang = 0;
    tick(20);
    final_report();
  end
endmodule : test_serial_control_channel_config
